// ### core/pin_sync.sv
module pin_sync
    import slic_ctl_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic pin,
    output logic      level
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;
    logic level_nxt;

    // The first stage feeds only the second; a change counts once stages two and three agree.
    always_comb
    begin
        level_nxt = (s2_r == s3_r) ? s3_r : level_r;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
        end
        else
        begin
            s1_r    <= pin;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign level = level_r;

endmodule : pin_sync

// ### core/ramp_gen.sv
module ramp_gen
    import slic_ctl_pkg::*;
#(
    parameter int W = 8
)
(
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic         tick,
    input  wire logic         up,
    output logic [W-1:0]      level,
    output logic              busy
);

    localparam logic [W-1:0] TOP = {W{1'b1}};
    localparam logic [W-1:0] BOT = {W{1'b0}};

    logic [W-1:0] level_r;
    logic [W-1:0] level_nxt;

    // One step per tick, so the slope is set by the tick rate rather than by the pin edge.
    always_comb
    begin
        level_nxt = level_r;
        if (tick && up && level_r != TOP)
        begin
            level_nxt = level_r + 1'b1;
        end
        else if (tick && !up && level_r != BOT)
        begin
            level_nxt = level_r - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            level_r <= BOT;
        end
        else
        begin
            level_r <= level_nxt;
        end
    end

    assign level = level_r;
    assign busy  = up ? (level_r != TOP) : (level_r != BOT);

endmodule : ramp_gen

// ### core/slic_ctl.sv
module slic_ctl
    import slic_ctl_pkg::*;
#(
    parameter int LEVEL_W = 8
)
(
    input  wire logic                sys_clk,
    input  wire logic                nrst,
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [DATA_W-1:0]   avs_writedata,
    output logic      [DATA_W-1:0]   avs_readdata,
    output logic                     avs_waitrequest,
    output logic                     irq,
    input  wire logic                power_down_ctl,
    input  wire logic                mode_select_low,
    input  wire logic                active_select,
    input  wire logic                polarity_select,
    input  wire logic                meter_tone_clock,
    input  wire logic                off_hook_sense,
    input  wire logic                ring_trip_sense,
    input  wire logic                loop_detect_n_in,
    output logic                     loop_detect_n_out,
    output logic                     loop_detect_n_oe,
    output logic      [LEVEL_W-1:0]  line_polarity_level,
    output logic                     polarity_ramp_busy,
    output logic      [LEVEL_W-1:0]  shaped_meter_wave,
    output logic                     meter_inject_en,
    output logic                     dc_loop_en,
    output logic                     ac_loop_en,
    output logic                     driver_buffer_mode,
    output logic                     line_powered
);

    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_s;

    assign pin_raw = {loop_detect_n_in, ring_trip_sense, off_hook_sense, meter_tone_clock,
                      polarity_select, active_select, mode_select_low, power_down_ctl};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++)
        begin : g_sync
            pin_sync u_sync (
                .sys_clk (sys_clk),
                .nrst    (nrst),
                .pin     (pin_raw[gi]),
                .level   (pin_s[gi])
            );
        end
    endgenerate

    mode_t mode;

    assign mode = decode_mode(pin_s[PIN_PD], pin_s[PIN_MSL], pin_s[PIN_ACT]);

    logic [DIV_W-1:0]  ramp_div_r;
    logic [DIV_W-1:0]  ramp_div_nxt;
    logic [DIV_W-1:0]  env_div_r;
    logic [DIV_W-1:0]  env_div_nxt;
    logic [INT_W-1:0]  int_mask_r;
    logic [INT_W-1:0]  int_mask_nxt;
    logic [INT_W-1:0]  int_status_r;
    logic [INT_W-1:0]  int_status_nxt;
    logic              ack_r;
    logic              ack_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    logic              pol_target_r;
    logic              pol_target_nxt;
    logic              trip_latch_r;
    logic              trip_latch_nxt;
    logic              det_r;
    logic              det_nxt;
    logic              pol_busy_d_r;
    logic              meter_on_d_r;
    logic [LEVEL_W-1:0] wave_r;
    logic [LEVEL_W-1:0] wave_nxt;
    logic              inject_r;
    logic              inject_nxt;
    logic [DIV_W-1:0]  ramp_cnt_r;
    logic [DIV_W-1:0]  ramp_cnt_nxt;
    logic [DIV_W-1:0]  env_cnt_r;
    logic [DIV_W-1:0]  env_cnt_nxt;
    logic              ramp_tick;
    logic              env_tick;
    logic              meter_gate;
    logic              pol_busy;
    logic              env_busy;
    logic [LEVEL_W-1:0] env_level;
    logic [INT_W-1:0]  events;

    // Polarity target follows the pin only where polarity has a meaning; in HI-Z and power
    // down the last polarity is kept so the line does not ramp while unfed.
    always_comb
    begin
        pol_target_nxt = pol_target_r;
        if (mode == MODE_ACTIVE || mode == MODE_METER || mode == MODE_RING)
        begin
            pol_target_nxt = pin_s[PIN_POL];
        end
    end

    // Step dividers for the reversal ramp and the meter envelope.
    always_comb
    begin
        ramp_tick    = (ramp_cnt_r >= ramp_div_r);
        env_tick     = (env_cnt_r >= env_div_r);
        ramp_cnt_nxt = ramp_tick ? '0 : ramp_cnt_r + 1'b1;
        env_cnt_nxt  = env_tick ? '0 : env_cnt_r + 1'b1;
    end

    ramp_gen #(
        .W (LEVEL_W)
    ) u_pol_ramp (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .tick    (ramp_tick),
        .up      (pol_target_r),
        .level   (line_polarity_level),
        .busy    (pol_busy)
    );

    assign meter_gate = (mode == MODE_METER);

    ramp_gen #(
        .W (LEVEL_W)
    ) u_env_ramp (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .tick    (env_tick),
        .up      (meter_gate),
        .level   (env_level),
        .busy    (env_busy)
    );

    // The envelope keeps decaying after the enable drops, so the tone must still run then.
    always_comb
    begin
        wave_nxt   = pin_s[PIN_TONE] ? env_level : '0;
        inject_nxt = (env_level != '0);
    end

    // Ring trip is held for the rest of the ring burst; leaving ring mode releases it.
    always_comb
    begin
        trip_latch_nxt = trip_latch_r;
        if (mode != MODE_RING)
        begin
            trip_latch_nxt = 1'b0;
        end
        else if (pin_s[PIN_TRIP])
        begin
            trip_latch_nxt = 1'b1;
        end
        case (mode)
            MODE_POWER_DOWN: det_nxt = 1'b0;
            MODE_RING:       det_nxt = trip_latch_nxt;
            MODE_HIZ,
            MODE_ACTIVE,
            MODE_METER:      det_nxt = pin_s[PIN_HOOK];
            default:         det_nxt = 1'b0;
        endcase
    end

    always_comb
    begin
        events                = '0;
        events[INT_RING_TRIP] = trip_latch_nxt & ~trip_latch_r;
        events[INT_HOOK]      = det_nxt ^ det_r;
        events[INT_POL_DONE]  = pol_busy_d_r & ~pol_busy;
        events[INT_METER_END] = meter_on_d_r & ~inject_r;
    end

    // Avalon slave: one wait cycle, answer on the second edge of the request.
    always_comb
    begin
        ack_nxt        = (avs_read | avs_write) & ~ack_r;
        rdata_nxt      = rdata_r;
        ramp_div_nxt   = ramp_div_r;
        env_div_nxt    = env_div_r;
        int_mask_nxt   = int_mask_r;
        int_status_nxt = int_status_r;
        if (avs_read && !ack_r)
        begin
            rdata_nxt = '0;
            case (avs_address)
                OFF_RAMP_DIV:   rdata_nxt[DIV_W-1:0] = ramp_div_r;
                OFF_ENV_DIV:    rdata_nxt[DIV_W-1:0] = env_div_r;
                OFF_INT_MASK:   rdata_nxt[INT_W-1:0] = int_mask_r;
                OFF_INT_STATUS: rdata_nxt[INT_W-1:0] = int_status_r;
                OFF_STATUS:
                begin
                    rdata_nxt[ST_MODE_LSB +: 3]       = mode;
                    rdata_nxt[ST_POL]                 = pol_target_r;
                    rdata_nxt[ST_RAMP_BUSY]           = pol_busy;
                    rdata_nxt[ST_DET]                 = det_r;
                    rdata_nxt[ST_RING_TRIP]           = trip_latch_r;
                    rdata_nxt[ST_METER]               = inject_r;
                    rdata_nxt[ST_LEVEL_LSB +: LEVEL_W] = line_polarity_level;
                    rdata_nxt[ST_DET_PIN]             = pin_s[PIN_DETIN];
                end
                default:        rdata_nxt = '0;
            endcase
        end
        if (avs_write && ack_r)
        begin
            case (avs_address)
                OFF_RAMP_DIV:   ramp_div_nxt   = avs_writedata[DIV_W-1:0];
                OFF_ENV_DIV:    env_div_nxt    = avs_writedata[DIV_W-1:0];
                OFF_INT_MASK:   int_mask_nxt   = avs_writedata[INT_W-1:0];
                OFF_INT_STATUS: int_status_nxt = int_status_r & ~avs_writedata[INT_W-1:0];
                default:        ;
            endcase
        end
        // A new event outranks a same-cycle clear.
        int_status_nxt = int_status_nxt | events;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ack_r        <= 1'b0;
            rdata_r      <= '0;
            ramp_div_r   <= RAMP_DIV_RST;
            env_div_r    <= ENV_DIV_RST;
            int_mask_r   <= INT_RST;
            int_status_r <= INT_RST;
            ramp_cnt_r   <= '0;
            env_cnt_r    <= '0;
            pol_target_r <= 1'b0;
            trip_latch_r <= 1'b0;
            det_r        <= 1'b0;
            pol_busy_d_r <= 1'b0;
            meter_on_d_r <= 1'b0;
            wave_r       <= '0;
            inject_r     <= 1'b0;
        end
        else
        begin
            ack_r        <= ack_nxt;
            rdata_r      <= rdata_nxt;
            ramp_div_r   <= ramp_div_nxt;
            env_div_r    <= env_div_nxt;
            int_mask_r   <= int_mask_nxt;
            int_status_r <= int_status_nxt;
            ramp_cnt_r   <= ramp_cnt_nxt;
            env_cnt_r    <= env_cnt_nxt;
            pol_target_r <= pol_target_nxt;
            trip_latch_r <= trip_latch_nxt;
            det_r        <= det_nxt;
            pol_busy_d_r <= pol_busy;
            meter_on_d_r <= inject_r;
            wave_r       <= wave_nxt;
            inject_r     <= inject_nxt;
        end
    end

    assign avs_waitrequest    = (avs_read | avs_write) & ~ack_r;
    assign avs_readdata       = rdata_r;
    assign irq                = |(int_status_r & int_mask_r);
    assign loop_detect_n_out  = 1'b0;
    assign loop_detect_n_oe   = det_r;
    assign polarity_ramp_busy = pol_busy;
    assign shaped_meter_wave  = wave_r;
    assign meter_inject_en    = inject_r;
    assign dc_loop_en         = (mode != MODE_POWER_DOWN) && (mode != MODE_RING);
    assign ac_loop_en         = (mode == MODE_ACTIVE) || (mode == MODE_METER);
    assign driver_buffer_mode = (mode == MODE_RING);
    assign line_powered       = (mode != MODE_POWER_DOWN);

endmodule : slic_ctl

// ### core/slic_ctl_pkg.sv
//Contract
//- Polarity pin low gives direct, high gives reversed polarity in active and ring.
//- Every polarity change swaps the wires through a ramp, never a step.
//- Mode-select-low held in active mode enables metering; hold time sets pulse length.
//- Meter tone clock, gated by enable, becomes an envelope-shaped wave for injection.
//- Ring mode disables DC and AC loops; drivers act as plain voltage buffers.
//- Ring trip during ringing drives loop detect to its active low level.
//- Ring mode: power-down high, mode-select-low high, active-select low.
//- Metering: power-down, mode-select-low, active-select all high; polarity still selectable.
//- Loop detect is an active-low open-drain output.
package slic_ctl_pkg;

    localparam int          ADDR_W         = 5;
    localparam int          DATA_W         = 32;
    localparam int          DIV_W          = 16;

    localparam logic [4:0]  OFF_RAMP_DIV   = 5'h00;
    localparam logic [4:0]  OFF_STATUS     = 5'h04;
    localparam logic [4:0]  OFF_INT_STATUS = 5'h08;
    localparam logic [4:0]  OFF_INT_MASK   = 5'h0C;
    localparam logic [4:0]  OFF_ENV_DIV    = 5'h10;

    localparam logic [15:0] RAMP_DIV_RST   = 16'h0100;
    localparam logic [15:0] ENV_DIV_RST    = 16'h0040;

    localparam int          INT_RING_TRIP  = 0;
    localparam int          INT_HOOK       = 1;
    localparam int          INT_POL_DONE   = 2;
    localparam int          INT_METER_END  = 3;
    localparam int          INT_W          = 4;
    localparam logic [3:0]  INT_RST        = 4'h0;

    localparam int          ST_MODE_LSB    = 0;
    localparam int          ST_POL         = 3;
    localparam int          ST_RAMP_BUSY   = 4;
    localparam int          ST_DET         = 5;
    localparam int          ST_RING_TRIP   = 6;
    localparam int          ST_METER       = 7;
    localparam int          ST_LEVEL_LSB   = 8;
    localparam int          ST_DET_PIN     = 16;

    localparam int          PIN_PD         = 0;
    localparam int          PIN_MSL        = 1;
    localparam int          PIN_ACT        = 2;
    localparam int          PIN_POL        = 3;
    localparam int          PIN_TONE       = 4;
    localparam int          PIN_HOOK       = 5;
    localparam int          PIN_TRIP       = 6;
    localparam int          PIN_DETIN      = 7;
    localparam int          PIN_N          = 8;

    typedef enum logic [2:0] {
        MODE_POWER_DOWN,
        MODE_HIZ,
        MODE_ACTIVE,
        MODE_METER,
        MODE_RING
    } mode_t;

    function automatic mode_t decode_mode(input logic pd, input logic msl, input logic act);
        mode_t m;
        m = MODE_POWER_DOWN;
        if (!pd)
        begin
            m = MODE_POWER_DOWN;
        end
        else if (act)
        begin
            m = msl ? MODE_METER : MODE_ACTIVE;
        end
        else
        begin
            m = msl ? MODE_RING : MODE_HIZ;
        end
        return m;
    endfunction : decode_mode

endpackage : slic_ctl_pkg

// ### sim/line_card_ctl.sv
module line_card_ctl
#(
    parameter int TONE_HALF = 10,
    parameter int RING_HALF = 300,
    parameter int DEB       = 4
)
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic [2:0] req_mode,
    input  wire logic       req_pol,
    input  wire logic       ring_go,
    input  wire logic       tone_on,
    input  wire logic       loop_pin,
    output logic            power_down_ctl,
    output logic            mode_select_low,
    output logic            active_select,
    output logic            polarity_select,
    output logic            meter_tone_clock,
    output logic            tripped
);
    timeunit 1ns;
    timeprecision 1ns;

    int   tone_cnt, ring_cnt, low_cnt;
    logic sync1, sync2;

    // The detect line is asynchronous and may bounce, so it is filtered before use.
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            {power_down_ctl, mode_select_low, active_select, polarity_select} <= 4'h0;
            {meter_tone_clock, tripped, sync1, sync2} <= 4'h3;
            {tone_cnt, ring_cnt, low_cnt} <= '0;
        end
        else
        begin
            sync1 <= loop_pin;
            sync2 <= sync1;
            low_cnt <= (ring_go && !sync2) ? low_cnt + 1 : 0;
            tone_cnt <= (tone_cnt + 1) % TONE_HALF;
            if (!tone_on)
                meter_tone_clock <= 1'b0;
            else if (tone_cnt == 0)
                meter_tone_clock <= !meter_tone_clock;
            if (!ring_go)
            begin
                tripped <= 1'b0;
                {power_down_ctl, mode_select_low, active_select} <= req_mode;
                polarity_select <= req_pol;
                ring_cnt <= 0;
            end
            else if (tripped || low_cnt >= DEB)
            begin
                tripped <= 1'b1;
                {power_down_ctl, mode_select_low, active_select} <= 3'h5;
            end
            else
            begin
                {power_down_ctl, mode_select_low, active_select} <= 3'h6;
                ring_cnt <= (ring_cnt + 1) % RING_HALF;
                if (ring_cnt == RING_HALF - 1)
                    polarity_select <= !polarity_select;
            end
        end
    end
endmodule : line_card_ctl

// ### sim/line_ring_meter_control_tb.sv
module line_ring_meter_control_tb
    import slic_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              sys_clk, nrst, avs_read, avs_write, avs_waitrequest, irq, loop_pin;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata, rd_d;
    logic              power_down_ctl, mode_select_low, active_select, polarity_select;
    logic              meter_tone_clock, off_hook_sense, ring_trip_sense, oe, od_out, busy;
    logic              inject, dc_en, ac_en, buf_md, powered, ring_go, tone_on, req_pol, tripped;
    logic [7:0]        level, wave, top;
    logic [2:0]        req_mode;
    logic [31:0]       shadow [0:7];
    logic [2:0]        modes [0:4] = '{3'h0, 3'h4, 3'h5, 3'h7, 3'h6};
    int                n_mismatch, tests_run, seed, i, cnt, p;

    assign loop_pin = oe ? od_out : 1'b1;

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    slic_ctl dut_u (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .power_down_ctl(power_down_ctl), .mode_select_low(mode_select_low),
        .active_select(active_select), .polarity_select(polarity_select),
        .meter_tone_clock(meter_tone_clock), .off_hook_sense(off_hook_sense),
        .ring_trip_sense(ring_trip_sense), .loop_detect_n_in(loop_pin),
        .loop_detect_n_out(od_out), .loop_detect_n_oe(oe), .line_polarity_level(level),
        .polarity_ramp_busy(busy), .shaped_meter_wave(wave), .meter_inject_en(inject),
        .dc_loop_en(dc_en), .ac_loop_en(ac_en), .driver_buffer_mode(buf_md),
        .line_powered(powered));

    line_card_ctl partner_u (.sys_clk(sys_clk), .nrst(nrst), .req_mode(req_mode),
        .req_pol(req_pol), .ring_go(ring_go), .tone_on(tone_on), .loop_pin(loop_pin),
        .power_down_ctl(power_down_ctl), .mode_select_low(mode_select_low),
        .active_select(active_select), .polarity_select(polarity_select),
        .meter_tone_clock(meter_tone_clock), .tripped(tripped));

    task automatic wrap_up();
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic hang(input int k, input int lim);
        if (k >= lim)
        begin
            n_mismatch++;
            wrap_up();
        end
    endtask : hang

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int k;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        for (k = 0; k < 20; k++)
        begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        hang(k, 20);
        rd_d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        if (a == OFF_RAMP_DIV || a == OFF_ENV_DIV)
            shadow[a[4:2]] = d & 32'h0000_FFFF;
        if (a == OFF_INT_MASK)
            shadow[3] = d & 32'h0000_000F;
        if (a == OFF_INT_STATUS)
            shadow[2] = shadow[2] & ~d;
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [31:0] m);
        bus(1'b0, a, 32'h0);
        chk("readdata", rd_d & m, shadow[a[4:2]] & m);
    endtask : rd

    task automatic st(input logic [31:0] v);
        shadow[2] = v;
        rd(OFF_INT_STATUS, 32'hF);
    endtask : st

    initial
    begin
        {nrst, avs_read, avs_write, off_hook_sense, ring_trip_sense} = 5'h0;
        {ring_go, tone_on, req_pol, req_mode, avs_address, avs_writedata} = '0;
        seed = 88;
        shadow = '{32'h100, 32'h10000, 32'h0, 32'h0, 32'h40, 32'h0, 32'h0, 32'h0};
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        for (i = 0; i < 8; i++)
            rd(5'(i * 4), 32'hFFFF_FFFF);
        for (i = 0; i < 8; i++)
            wr(5'(i * 4), $random(seed));
        for (i = 0; i < 8; i++)
            rd(5'(i * 4), 32'hFFFF_FFFF);
        chk("irq", irq, 1'b0);
        wr(OFF_RAMP_DIV, 32'h0);
        wr(OFF_ENV_DIV, 32'h0);
        wr(OFF_INT_MASK, 32'h0000_000B);
        for (i = 0; i < 5; i++)
        begin
            req_mode <= modes[i];
            repeat (8) @(posedge sys_clk);
            shadow[1] = i;
            rd(OFF_STATUS, 32'h7);
            chk("loops", {dc_en, ac_en, buf_md, powered},
                {i > 0 && i < 4, i == 2 || i == 3, i == 4, i != 0});
        end
        repeat (300) @(posedge sys_clk);
        st(32'h8);
        chk("irq", irq, 1'b1);
        wr(OFF_INT_STATUS, 32'h8);
        chk("irq", irq, 1'b0);
        req_mode <= 3'h5;
        for (p = 1; p >= 0; p--)
        begin
            req_pol <= p[0];
            for (i = 0; i < 20 && busy !== 1'b1; i++)
                @(posedge sys_clk);
            hang(i, 20);
            for (cnt = 0; cnt < 1000 && busy === 1'b1; cnt++)
                @(posedge sys_clk);
            hang(cnt, 1000);
            chk("ramp_len", cnt, 255);
            chk("level", level, p ? 8'hFF : 8'h00);
            st(32'h4);
            chk("irq", irq, 1'b0);
            wr(OFF_INT_MASK, 32'hF);
            chk("irq", irq, 1'b1);
            wr(OFF_INT_STATUS, 32'h4);
            chk("irq", irq, 1'b0);
            wr(OFF_INT_MASK, 32'hB);
        end
        tone_on <= 1'b1;
        req_mode <= 3'h7;
        top = 8'h0;
        for (i = 0; i < 200; i++)
        begin
            @(posedge sys_clk);
            top = (wave > top) ? wave : top;
        end
        chk("inject", inject, 1'b1);
        chk("wave", top != 8'h0, 1'b1);
        req_mode <= 3'h5;
        for (i = 0; i < 600 && inject !== 1'b0; i++)
            @(posedge sys_clk);
        hang(i, 600);
        tone_on <= 1'b0;
        st(32'h8);
        wr(OFF_INT_STATUS, 32'h8);
        ring_go <= 1'b1;
        top = 8'h0;
        for (i = 0; i < 700; i++)
        begin
            @(posedge sys_clk);
            top = (level > top) ? level : top;
        end
        chk("ring_level", top, 8'hFF);
        chk("ring_buf", buf_md, 1'b1);
        off_hook_sense <= 1'b1;
        ring_trip_sense <= 1'b1;
        for (i = 0; i < 100 && tripped !== 1'b1; i++)
            @(posedge sys_clk);
        hang(i, 100);
        chk("trip_pin", loop_pin, 1'b0);
        repeat (300) @(posedge sys_clk);
        shadow[1] = 32'h22;
        rd(OFF_STATUS, 32'h67);
        st(32'h7);
        chk("irq", irq, 1'b1);
        wrap_up();
    end
endmodule : line_ring_meter_control_tb

// ### sim/slic_ctl_sva.sv
module slic_ctl_sva
    import slic_ctl_pkg::*;
#(
    parameter int LEVEL_W = 8
)
(
    input wire logic               sys_clk,
    input wire logic               nrst,
    input wire logic               power_down_ctl,
    input wire logic               mode_select_low,
    input wire logic               active_select,
    input wire logic               polarity_select,
    input wire logic               meter_tone_clock,
    input wire logic               ring_trip_sense,
    input wire logic               loop_detect_n_out,
    input wire logic               loop_detect_n_oe,
    input wire logic [LEVEL_W-1:0] line_polarity_level,
    input wire logic [LEVEL_W-1:0] shaped_meter_wave,
    input wire logic               meter_inject_en,
    input wire logic               dc_loop_en,
    input wire logic               ac_loop_en,
    input wire logic               driver_buffer_mode
);
    logic       pol_hi, pol_lo, ring_pins, meter_pins;
    logic [3:0] since_meter_r, since_meter_nxt;

    assign pol_hi = power_down_ctl & active_select & polarity_select;
    assign pol_lo = power_down_ctl & active_select & ~polarity_select;
    assign ring_pins = power_down_ctl & mode_select_low & ~active_select;
    assign meter_pins = power_down_ctl & mode_select_low & active_select;

    // The pins pass a synchroniser, so a start may trail the request by a few clocks.
    always_comb
        since_meter_nxt = meter_pins ? 4'h0 : since_meter_r + {3'h0, since_meter_r != 4'hF};

    always_ff @(posedge sys_clk or negedge nrst)
        if (!nrst)
            since_meter_r <= 4'hF;
        else
            since_meter_r <= since_meter_nxt;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_ramp_step;
        (line_polarity_level == $past(line_polarity_level))
        || (line_polarity_level == $past(line_polarity_level) + 1'b1)
        || (line_polarity_level == $past(line_polarity_level) - 1'b1);
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("polarity level jumped");
    property p_pol_up;
        pol_hi[*8] |-> line_polarity_level >= $past(line_polarity_level);
    endproperty
    a_pol_up: assert property (p_pol_up) else $error("level fell while reversed");
    property p_pol_down;
        pol_lo[*8] |-> line_polarity_level <= $past(line_polarity_level);
    endproperty
    a_pol_down: assert property (p_pol_down) else $error("level rose while direct");
    property p_ring_buf;
        ring_pins[*6] |-> driver_buffer_mode && !dc_loop_en && !ac_loop_en;
    endproperty
    a_ring_buf: assert property (p_ring_buf) else $error("loops on in ring mode");
    property p_meter_loops;
        meter_pins[*6] |-> dc_loop_en && ac_loop_en && !driver_buffer_mode;
    endproperty
    a_meter_loops: assert property (p_meter_loops) else $error("metering loops wrong");
    property p_tone_gate;
        (!meter_tone_clock)[*6] |-> shaped_meter_wave == '0;
    endproperty
    a_tone_gate: assert property (p_tone_gate) else $error("wave without tone");
    property p_meter_start;
        $rose(meter_inject_en) |-> since_meter_r < 4'h8;
    endproperty
    a_meter_start: assert property (p_meter_start) else $error("injection not asked");
    property p_trip;
        (ring_pins && ring_trip_sense)[*6] |-> ##[0:4] loop_detect_n_oe;
    endproperty
    a_trip: assert property (p_trip) else $error("ring trip not reported");
    property p_pd_quiet;
        (!power_down_ctl)[*8] |-> !loop_detect_n_oe;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("detect in power down");
    property p_open_drain;
        loop_detect_n_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("detect drives high");
endmodule : slic_ctl_sva

bind slic_ctl slic_ctl_sva #(.LEVEL_W(LEVEL_W)) sva_u (.sys_clk(sys_clk), .nrst(nrst),
    .power_down_ctl(power_down_ctl), .mode_select_low(mode_select_low),
    .active_select(active_select), .polarity_select(polarity_select),
    .meter_tone_clock(meter_tone_clock), .ring_trip_sense(ring_trip_sense),
    .loop_detect_n_out(loop_detect_n_out), .loop_detect_n_oe(loop_detect_n_oe),
    .line_polarity_level(line_polarity_level), .shaped_meter_wave(shaped_meter_wave),
    .meter_inject_en(meter_inject_en), .dc_loop_en(dc_loop_en), .ac_loop_en(ac_loop_en),
    .driver_buffer_mode(driver_buffer_mode));
